// ===== hw/sbsa_mem_controller.sv
// controller end: divides clk into the link clock and runs burst accesses
`timescale 1ns/1ps
`include "sbsa_defines.svh"
module sbsa_mem_controller #(
   parameter int ADDR_W = `SBSA_ADDR_W,
   parameter bit SINGLE_CLK = 1'b1
) (
   input wire logic clk,
   input wire logic sys_rst,
   sbsa_link_if.controller link,
   input wire logic reqValid,
   output logic reqReady,
   input wire logic reqWrite,
   input wire logic [ADDR_W-1:0] reqAddr,
   input wire logic [`SBSA_BURST_W-1:0] reqWrData,
   input wire logic [2*`SBSA_LANES-1:0] reqLaneSel_n,
   output logic rdValid,
   output logic [`SBSA_BURST_W-1:0] rdWord
);
   localparam int WW = `SBSA_WORD_W;

   ////////////////////////////////////////////////////////////////////////////
   // state
   sbsa_pkg::sbsa_phase_t phase_reg, phase_next;
   logic linkRst_reg, linkRst_next;
   logic ld_n_reg, ld_n_next;
   logic rw_reg, rw_next;
   logic [ADDR_W-1:0] addr_reg, addr_next;
   logic stgValid_reg, stgValid_next;
   logic [`SBSA_BURST_W-1:0] stgData_reg, stgData_next;
   logic [2*`SBSA_LANES-1:0] stgSel_reg, stgSel_next;
   logic w1Pend_reg, w1Pend_next;
   logic [WW-1:0] w1Data_reg, w1Data_next;
   logic [`SBSA_LANES-1:0] w1Sel_reg, w1Sel_next;
   logic [WW-1:0] d_reg, d_next;
   logic [`SBSA_LANES-1:0] sel_reg, sel_next;
   logic [WW-1:0] qSync1_reg, qSync2_reg;
   logic oeSync1_reg, oeSync2_reg;
   logic lowHave_reg, lowHave_next;
   logic [WW-1:0] rdLow_reg, rdLow_next;
   logic rdValid_reg, rdValid_next;
   logic [`SBSA_BURST_W-1:0] rdWord_reg, rdWord_next;
   logic take;

   ////////////////////////////////////////////////////////////////////////////
   // link clock from the phase counter; outputs clocks tied high in single mode
   assign link.kClk = (phase_reg == sbsa_pkg::SBSA_PH_HIGH0) || (phase_reg == sbsa_pkg::SBSA_PH_HIGH1);
   assign link.kClkN = !link.kClk;
   assign link.cClk = SINGLE_CLK ? 1'b1 : link.kClk;
   assign link.cClkN = SINGLE_CLK ? 1'b1 : link.kClkN;
   assign link.linkRst = linkRst_reg;
   assign link.load_strobe_n = ld_n_reg;
   assign link.rdWrSel = rw_reg;
   assign link.addr = addr_reg;
   assign link.wrData = d_reg;
   assign link.byte_lane_select_n = sel_reg;

   // one request per link period, taken a quarter period before the rise
   assign reqReady = (phase_reg == sbsa_pkg::SBSA_PH_LOW0) && !linkRst_reg;
   assign take = reqReady && reqValid;
   assign rdValid = rdValid_reg;
   assign rdWord = rdWord_reg;

   ////////////////////////////////////////////////////////////////////////////
   // next-state: commands change mid-low, second word mid-high, away from edges
   always_comb begin
      phase_next = phase_reg;
      case (phase_reg)
         sbsa_pkg::SBSA_PH_HIGH0: phase_next = sbsa_pkg::SBSA_PH_HIGH1;
         sbsa_pkg::SBSA_PH_HIGH1: phase_next = sbsa_pkg::SBSA_PH_LOW0;
         sbsa_pkg::SBSA_PH_LOW0: phase_next = sbsa_pkg::SBSA_PH_LOW1;
         sbsa_pkg::SBSA_PH_LOW1: phase_next = sbsa_pkg::SBSA_PH_HIGH0;
         default: phase_next = sbsa_pkg::SBSA_PH_HIGH0;
      endcase
      // reset release is aligned mid-low so the device sees a clean level
      linkRst_next = (phase_reg == sbsa_pkg::SBSA_PH_LOW0) ? 1'b0 : linkRst_reg;
      ld_n_next = ld_n_reg;
      rw_next = rw_reg;
      addr_next = addr_reg;
      stgValid_next = stgValid_reg;
      stgData_next = stgData_reg;
      stgSel_next = stgSel_reg;
      w1Pend_next = w1Pend_reg;
      w1Data_next = w1Data_reg;
      w1Sel_next = w1Sel_reg;
      d_next = d_reg;
      sel_next = sel_reg;
      if (phase_reg == sbsa_pkg::SBSA_PH_LOW0) begin
         ld_n_next = !take;
         rw_next = take ? !reqWrite : rw_reg;
         addr_next = take ? reqAddr : addr_reg;
         // a write loaded last period sends its first word for this rise
         d_next = stgData_reg[WW-1:0];
         sel_next = stgValid_reg ? stgSel_reg[`SBSA_LANES-1:0] : `SBSA_LANES_OFF;
         w1Pend_next = stgValid_reg;
         w1Data_next = stgData_reg[`SBSA_BURST_W-1:WW];
         w1Sel_next = stgSel_reg[2*`SBSA_LANES-1:`SBSA_LANES];
         stgValid_next = take && reqWrite;
         stgData_next = take ? reqWrData : stgData_reg;
         stgSel_next = take ? reqLaneSel_n : stgSel_reg;
      end
      if (phase_reg == sbsa_pkg::SBSA_PH_HIGH0) begin
         // second word for the coming fall
         d_next = w1Pend_reg ? w1Data_reg : d_reg;
         sel_next = w1Pend_reg ? w1Sel_reg : `SBSA_LANES_OFF;
         w1Pend_next = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read capture: synced pins read two clk edges after each launch
   always_comb begin
      lowHave_next = lowHave_reg;
      rdLow_next = rdLow_reg;
      rdValid_next = 1'b0;
      rdWord_next = rdWord_reg;
      if (phase_reg == sbsa_pkg::SBSA_PH_HIGH0 && oeSync2_reg) begin
         rdLow_next = qSync2_reg;
         lowHave_next = 1'b1;
      end
      if (phase_reg == sbsa_pkg::SBSA_PH_LOW0 && oeSync2_reg && lowHave_reg) begin
         rdWord_next = {qSync2_reg, rdLow_reg};
         rdValid_next = 1'b1;
         lowHave_next = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      qSync1_reg <= link.rdData;
      qSync2_reg <= qSync1_reg;
      oeSync1_reg <= link.rdDataOe;
      oeSync2_reg <= oeSync1_reg;
      rdLow_reg <= rdLow_next;
      rdWord_reg <= rdWord_next;
      stgData_reg <= stgData_next;
      stgSel_reg <= stgSel_next;
      w1Data_reg <= w1Data_next;
      w1Sel_reg <= w1Sel_next;
      addr_reg <= addr_next;
      d_reg <= d_next;
      // the divider runs through reset so the device clocks linkRst in on its own rises
      phase_reg <= phase_next;
      if (sys_rst) begin
         linkRst_reg <= 1'b1;
         ld_n_reg <= 1'b1;
         rw_reg <= 1'b1;
         stgValid_reg <= 1'b0;
         w1Pend_reg <= 1'b0;
         sel_reg <= `SBSA_LANES_OFF;
         lowHave_reg <= 1'b0;
         rdValid_reg <= 1'b0;
      end else begin
         linkRst_reg <= linkRst_next;
         ld_n_reg <= ld_n_next;
         rw_reg <= rw_next;
         stgValid_reg <= stgValid_next;
         w1Pend_reg <= w1Pend_next;
         sel_reg <= sel_next;
         lowHave_reg <= lowHave_next;
         rdValid_reg <= rdValid_next;
      end
   end
endmodule // sbsa_mem_controller

// ===== hw/sbsa_defines.svh
// constants shared by both ends of the two-word burst sram link
`ifndef SBSA_DEFINES_SVH
`define SBSA_DEFINES_SVH
`define SBSA_ADDR_W 20
`define SBSA_WORD_W 18
`define SBSA_BURST_W 36
`define SBSA_LANE0_LSB 0
`define SBSA_LANE0_MSB 8
`define SBSA_LANE1_LSB 9
`define SBSA_LANE1_MSB 17
`define SBSA_LANES 2
`define SBSA_CLK_PERIOD_NS 20
`define SBSA_K_PERIOD_NS 80
`define SBSA_K_PHASES (`SBSA_K_PERIOD_NS / `SBSA_CLK_PERIOD_NS)
`define SBSA_LANES_OFF 2'h3
`endif

// ===== hw/sbsa_pkg.sv
// types used by the controller end of the two-word burst sram link
package sbsa_pkg;
   // phase of the divided link clock inside one period, gray along the cycle
   typedef enum logic [1:0] {
      SBSA_PH_HIGH0 = 2'h0,
      SBSA_PH_HIGH1 = 2'h1,
      SBSA_PH_LOW0 = 2'h3,
      SBSA_PH_LOW1 = 2'h2
   } sbsa_phase_t;
endpackage

// ===== hw/sbsa_link_if.sv
// pin-level link between the burst sram and its memory controller
`timescale 1ns/1ps
`include "sbsa_defines.svh"
interface sbsa_link_if #(
   parameter int ADDR_W = `SBSA_ADDR_W
);
   logic kClk;
   logic kClkN;
   logic cClk;
   logic cClkN;
   logic linkRst;
   logic load_strobe_n;
   logic rdWrSel;
   logic [ADDR_W-1:0] addr;
   logic [`SBSA_LANES-1:0] byte_lane_select_n;
   logic [`SBSA_WORD_W-1:0] wrData;
   logic [`SBSA_WORD_W-1:0] rdData;
   logic rdDataOe;

   modport device (
      input kClk,
      input kClkN,
      input cClk,
      input cClkN,
      input linkRst,
      input load_strobe_n,
      input rdWrSel,
      input addr,
      input byte_lane_select_n,
      input wrData,
      output rdData,
      output rdDataOe
   );

   modport controller (
      output kClk,
      output kClkN,
      output cClk,
      output cClkN,
      output linkRst,
      output load_strobe_n,
      output rdWrSel,
      output addr,
      output byte_lane_select_n,
      output wrData,
      input rdData,
      input rdDataOe
   );
endinterface // sbsa_link_if

// ===== hw/sbsa_sram_device.sv
// burst sram end: two-word bursts, byte lanes, posted writes, ddr read port
`timescale 1ns/1ps
`include "sbsa_defines.svh"
module sbsa_sram_device #(
   parameter int ADDR_W = `SBSA_ADDR_W
) (
   sbsa_link_if.device link
);
   localparam int WW = `SBSA_WORD_W;
   localparam int BW = `SBSA_BURST_W;

   ////////////////////////////////////////////////////////////////////////////
   // merge one burst into stored data, lane by lane, select active low
   // shared by the array write and the read bypass so both always agree
   function automatic logic [BW-1:0] laneMerge(
      input logic [BW-1:0] old,
      input logic [BW-1:0] fresh,
      input logic [2*`SBSA_LANES-1:0] sel_n
   );
      logic [BW-1:0] res;
      res = old;
      for (int w = 0; w < 2; w++) begin
         if (!sel_n[2*w]) begin
            res[w*WW+`SBSA_LANE0_LSB +: `SBSA_LANE0_MSB+1] =
               fresh[w*WW+`SBSA_LANE0_LSB +: `SBSA_LANE0_MSB+1];
         end
         if (!sel_n[2*w+1]) begin
            res[w*WW+`SBSA_LANE1_LSB +: `SBSA_LANE1_MSB-`SBSA_LANE1_LSB+1] =
               fresh[w*WW+`SBSA_LANE1_LSB +: `SBSA_LANE1_MSB-`SBSA_LANE1_LSB+1];
         end
      end
      return res;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // reset and strap synchronisers on the input clock
   // the controller keeps the link clock running through reset so these see it
   logic rstSync1_reg, rstSync2_reg;
   logic strapSync1_reg, strapSync2_reg;
   logic singleMode_reg, singleMode_next;

   // strap only follows while in reset, frozen afterwards
   always_comb begin
      singleMode_next = rstSync2_reg ? strapSync2_reg : singleMode_reg;
   end

   always_ff @(posedge link.kClk) begin
      rstSync1_reg <= link.linkRst;
      rstSync2_reg <= rstSync1_reg;
      strapSync1_reg <= link.cClk & link.cClkN;
      strapSync2_reg <= strapSync1_reg;
      singleMode_reg <= singleMode_next;
   end

   ////////////////////////////////////////////////////////////////////////////
   // memory array: flops, one burst-wide entry per location
   // the array is not reset: a location never written reads back unknown
   logic [BW-1:0] mem [0:(1<<ADDR_W)-1];

   // pending (posted) write, filled on the input clock fall
   logic pendValid_reg, pendValid_next;
   logic [ADDR_W-1:0] pendAddr_reg, pendAddr_next;
   logic [BW-1:0] pendData_reg, pendData_next;
   logic [2*`SBSA_LANES-1:0] pendSel_reg, pendSel_next;

   ////////////////////////////////////////////////////////////////////////////
   // command and data capture on the input clock rise
   // read and write addresses are kept apart so a posted write survives reads
   logic rdLoad_reg, rdLoad_next;
   logic wrLoad_reg, wrLoad_next;
   logic wrColl_reg, wrColl_next;
   logic [ADDR_W-1:0] rdAddr_reg, rdAddr_next;
   logic [ADDR_W-1:0] wrAddr_reg, wrAddr_next;
   logic [ADDR_W-1:0] collAddr_reg, collAddr_next;
   logic [WW-1:0] word0_reg, word0_next;
   logic [`SBSA_LANES-1:0] sel0_reg, sel0_next;
   logic fetchValid_reg, fetchValid_next;
   logic [BW-1:0] fetch_reg, fetch_next;
   logic commit;

   always_comb begin
      logic [BW-1:0] stored;
      stored = mem[rdAddr_reg];
      // strobe low at the rise is the only way to start an access
      rdLoad_next = !rstSync2_reg && !link.load_strobe_n && link.rdWrSel;
      wrLoad_next = !rstSync2_reg && !link.load_strobe_n && !link.rdWrSel;
      rdAddr_next = rdLoad_next ? link.addr : rdAddr_reg;
      wrAddr_next = wrLoad_next ? link.addr : wrAddr_reg;
      // first write word arrives one rise after the load
      wrColl_next = wrLoad_reg && !rstSync2_reg;
      collAddr_next = wrLoad_reg ? wrAddr_reg : collAddr_reg;
      word0_next = wrLoad_reg ? link.wrData : word0_reg;
      sel0_next = wrLoad_reg ? link.byte_lane_select_n : sel0_reg;
      // the posted write goes to the array at the first-word rise of the next write;
      // committing on the load instead would let a second write's fall overwrite an
      // uncommitted first write whenever two writes run back to back
      commit = wrLoad_reg && pendValid_reg;
      // fetch one rise after the read load, bypassing the posted write
      fetchValid_next = rdLoad_reg && !rstSync2_reg;
      fetch_next = fetch_reg;
      if (rdLoad_reg) begin
         fetch_next = (pendValid_reg && pendAddr_reg == rdAddr_reg) ?
            laneMerge(stored, pendData_reg, pendSel_reg) : stored;
      end
   end

   always_ff @(posedge link.kClk) begin
      rdLoad_reg <= rdLoad_next;
      wrLoad_reg <= wrLoad_next;
      wrColl_reg <= wrColl_next;
      rdAddr_reg <= rdAddr_next;
      wrAddr_reg <= wrAddr_next;
      collAddr_reg <= collAddr_next;
      word0_reg <= word0_next;
      sel0_reg <= sel0_next;
      fetchValid_reg <= fetchValid_next;
      fetch_reg <= fetch_next;
   end

   // array write port; only a commit touches the array
   always_ff @(posedge link.kClk) begin
      if (commit) begin
         mem[pendAddr_reg] <= laneMerge(mem[pendAddr_reg], pendData_reg, pendSel_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // second write word on the input clock fall completes the burst; a link reset
   // drops a write still posted, so the controller must not reset with one pending
   always_comb begin
      pendValid_next = pendValid_reg;
      pendAddr_next = pendAddr_reg;
      pendData_next = pendData_reg;
      pendSel_next = pendSel_reg;
      if (rstSync2_reg) begin
         pendValid_next = 1'b0;
      end else if (wrColl_reg) begin
         pendValid_next = 1'b1;
         pendAddr_next = collAddr_reg;
         pendData_next = {link.wrData, word0_reg};
         pendSel_next = {link.byte_lane_select_n, sel0_reg};
      end
   end

   always_ff @(negedge link.kClk) begin
      pendValid_reg <= pendValid_next;
      pendAddr_reg <= pendAddr_next;
      pendData_reg <= pendData_next;
      pendSel_reg <= pendSel_next;
   end

   ////////////////////////////////////////////////////////////////////////////
   // ddr output stage: fall register launches word 0, rise register word 1
   // output clock pair is assumed phase-aligned to the input pair; no crossing
   // the clock mux only switches while the strap is captured, inside reset
   logic outClk;
   logic [WW-1:0] qFall_reg, qRise_reg, qHi_reg;
   logic [WW-1:0] qFall_next, qRise_next, qHi_next;
   logic oeFall_reg, oeRise_reg;
   logic oeFall_next, oeRise_next;
   assign outClk = singleMode_reg ? link.kClk : link.cClk;

   // launch values; no fetched burst means the pins float from the next fall
   always_comb begin
      oeFall_next = rstSync2_reg ? 1'b0 : fetchValid_reg;
      qFall_next = fetch_reg[WW-1:0];
      qHi_next = fetch_reg[BW-1:WW];
      // the rise register only repeats what the fall staged half a period before
      oeRise_next = rstSync2_reg ? 1'b0 : oeFall_reg;
      qRise_next = qHi_reg;
   end

   always_ff @(negedge outClk) begin
      oeFall_reg <= oeFall_next;
      qFall_reg <= qFall_next;
      qHi_reg <= qHi_next;
   end

   always_ff @(posedge outClk) begin
      oeRise_reg <= oeRise_next;
      qRise_reg <= qRise_next;
   end

   // clock-level select forms the double-rate pin from two launch registers
   assign link.rdData = outClk ? qRise_reg : qFall_reg;
   assign link.rdDataOe = outClk ? oeRise_reg : oeFall_reg;
endmodule // sbsa_sram_device

// ===== bench/sbsa_link_chk.sv
// pin-level checks on the burst sram link, clocked by the link clock
`timescale 1ns/1ps
`include "sbsa_defines.svh"
module sbsa_link_chk #(
   parameter int ADDR_W = `SBSA_ADDR_W
) (
   input wire logic kClk,
   input wire logic kClkN,
   input wire logic cClk,
   input wire logic cClkN,
   input wire logic linkRst,
   input wire logic load_strobe_n,
   input wire logic rdWrSel,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [`SBSA_LANES-1:0] byte_lane_select_n,
   input wire logic [`SBSA_WORD_W-1:0] wrData,
   input wire logic [`SBSA_WORD_W-1:0] rdData,
   input wire logic rdDataOe
);
   ////////////////////////////////////////////////////////////
   // command decodes as the pins show them
   logic rdCmd;
   logic wrCmd;
   assign rdCmd = !load_strobe_n && rdWrSel;
   assign wrCmd = !load_strobe_n && !rdWrSel;

   // a read is a load followed by two beats on the output pair
   sequence sReadIssued;
      rdCmd;
   endsequence
   sequence sDriveTwo;
      ##2 rdDataOe;
   endsequence
   sequence sFloatTwo;
      ##2 !rdDataOe;
   endsequence

   ////////////////////////////////////////////////////////////
   // rising-edge view sees word0, falling-edge view sees word1
   chk_rd_word0: assert property (@(posedge kClk) disable iff (linkRst) sReadIssued |-> sDriveTwo)
      else $error("read word0 not driven on time");
   chk_rd_word1: assert property (@(negedge kClk) disable iff (linkRst) sReadIssued |-> sDriveTwo)
      else $error("read word1 not driven on time");
   chk_nop_float: assert property (@(posedge kClk) disable iff (linkRst) !rdCmd |-> sFloatTwo)
      else $error("output driven without a read");
   chk_float_after: assert property (@(negedge kClk) disable iff (linkRst) !rdCmd |-> sFloatTwo)
      else $error("output not released after read");
   chk_lanes_word0: assert property (@(posedge kClk) disable iff (linkRst)
      !wrCmd |=> byte_lane_select_n == `SBSA_LANES_OFF)
      else $error("lane select active without write word0");
   chk_lanes_word1: assert property (@(negedge kClk) disable iff (linkRst)
      !wrCmd |=> byte_lane_select_n == `SBSA_LANES_OFF)
      else $error("lane select active without write word1");
   // strap is sampled in reset and must not move afterwards
   chk_strap_high: assert property (@(posedge kClk) disable iff (linkRst) cClk && cClkN)
      else $error("single-clock strap not held high");
   chk_kbar_comp: assert property (@(posedge kClk) disable iff (linkRst) !kClk |-> kClkN)
      else $error("negative input clock not complementary");
endmodule // sbsa_link_chk

// ===== bench/tb_sio_burst2_sram_access.sv
// self-checking bench: controller and burst sram joined across the link interface
`timescale 1ns/1ps
`include "sbsa_defines.svh"
module tb_sio_burst2_sram_access;
   typedef struct packed {
      logic wr;
      logic [`SBSA_ADDR_W-1:0] a;
      logic [`SBSA_BURST_W-1:0] d;
      logic [3:0] ln;
   } sbsa_row_t;
   logic clk;
   logic sys_rst;
   logic reqValid;
   logic reqReady;
   logic reqWrite;
   logic [`SBSA_ADDR_W-1:0] reqAddr;
   logic [`SBSA_BURST_W-1:0] reqWrData;
   logic [3:0] reqLaneSel_n;
   logic rdValid;
   logic [`SBSA_BURST_W-1:0] rdWord;
   logic [`SBSA_BURST_W-1:0] model [int];
   logic [`SBSA_BURST_W-1:0] expQ [$];
   int errors;
   int tests_run;
   sbsa_row_t rows [8];

   sbsa_link_if link ();
   sbsa_mem_controller sbsa_mem_controller_inst (.clk(clk), .sys_rst(sys_rst), .link(link), .reqValid(reqValid),
      .reqReady(reqReady), .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWrData(reqWrData),
      .reqLaneSel_n(reqLaneSel_n), .rdValid(rdValid), .rdWord(rdWord));
   sbsa_sram_device sbsa_sram_device_inst (.link(link));
   sbsa_link_chk sbsa_link_chk_inst (.kClk(link.kClk), .kClkN(link.kClkN), .cClk(link.cClk), .cClkN(link.cClkN),
      .linkRst(link.linkRst), .load_strobe_n(link.load_strobe_n), .rdWrSel(link.rdWrSel), .addr(link.addr),
      .byte_lane_select_n(link.byte_lane_select_n), .wrData(link.wrData), .rdData(link.rdData),
      .rdDataOe(link.rdDataOe));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////
   // comparisons and the closing report
   task automatic chk_word(input string what, input logic [35:0] exp, input logic [35:0] got);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_flag(input string what, input logic exp, input logic got);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // reference contents: each cleared select lets its 9-bit lane through
   function automatic logic [35:0] merge(input logic [35:0] old, input logic [35:0] d, input logic [3:0] ln);
      logic [35:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (!ln[i]) begin
            r[i*9 +: 9] = d[i*9 +: 9];
         end
      end
      return r;
   endfunction

   // request held from a falling edge until the rising edge that takes it; valid stays up for back-to-back use
   task automatic issue(input sbsa_row_t r);
      int i;
      reqValid = 1'b1;
      reqWrite = r.wr;
      reqAddr = r.a;
      reqWrData = r.d;
      reqLaneSel_n = r.ln;
      for (i = 0; i < 8 && reqReady !== 1'b1; i++) begin
         @(negedge clk);
      end
      if (i == 8) begin
         errors++;
         $display("Error handshake expected ready seen timeout");
         conclude();
      end else begin
         if (r.wr) begin
            model[r.a] = merge(model.exists(r.a) ? model[r.a] : 36'hXXXXXXXXX, r.d, r.ln);
         end else begin
            expQ.push_back(model[r.a]);
         end
         @(negedge clk);
      end
   endtask

   // stop requesting, wait for outstanding reads, then the link must be quiet
   task automatic drain();
      int i;
      reqValid = 1'b0;
      for (i = 0; i < 60 && expQ.size() != 0; i++) begin
         @(negedge clk);
      end
      if (expQ.size() != 0) begin
         errors++;
         $display("Error read count expected 0 seen %0d", expQ.size());
         conclude();
      end else begin
         repeat (8) @(negedge clk);
         chk_flag("output enable idle", 1'b0, link.rdDataOe);
         chk_flag("lanes idle", 1'b1, link.byte_lane_select_n == `SBSA_LANES_OFF);
      end
   endtask

   // read results are picked up mid-cycle, clear of the register updates
   always @(negedge clk) begin
      if (rdValid === 1'b1) begin
         if (expQ.size() == 0) begin
            errors++;
            $display("Error read data expected none seen %h", rdWord);
         end else begin
            chk_word("read burst", expQ.pop_front(), rdWord);
         end
      end
   end

   ////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      sys_rst = 1'b1;
      reqValid = 1'b0;
      reqWrite = 1'b0;
      reqAddr = 20'h00000;
      reqWrData = 36'h000000000;
      reqLaneSel_n = 4'hF;
      errors = 0;
      tests_run = 0;
      // plain cases, including both address ends and a partial lane write
      rows = '{'{1'b1, 20'h00000, 36'h123456789, 4'h0}, '{1'b1, 20'hFFFFF, 36'hFEDCBA987, 4'h0},
         '{1'b1, 20'h00005, 36'h0A5A5A5A5, 4'h0}, '{1'b0, 20'h00000, 36'h000000000, 4'hF},
         '{1'b0, 20'hFFFFF, 36'h000000000, 4'hF}, '{1'b1, 20'h00000, 36'h3C3C3C3C3, 4'hA},
         '{1'b0, 20'h00000, 36'h000000000, 4'hF}, '{1'b0, 20'h00005, 36'h000000000, 4'hF}};
      repeat (20) @(negedge clk);
      chk_flag("ready in reset", 1'b0, reqReady);
      chk_flag("read valid in reset", 1'b0, rdValid);
      sys_rst = 1'b0;
      repeat (20) @(negedge clk);
      foreach (rows[k]) begin
         issue(rows[k]);
      end
      drain();
      // every lane code, each write read back at once from the posted register
      for (int l = 0; l < 16; l++) begin
         issue('{1'b1, 20'h00005, {4{5'h15, l[3:0]}}, l[3:0]});
         issue('{1'b0, 20'h00005, 36'h000000000, 4'hF});
      end
      drain();
      // a second reset in mid-run: array contents survive, link restarts
      issue('{1'b1, 20'h00009, 36'h5A5A5A5A5, 4'h0});
      issue('{1'b1, 20'h0000A, 36'h111111111, 4'h0});
      drain();
      sys_rst = 1'b1;
      repeat (20) @(negedge clk);
      chk_flag("ready in second reset", 1'b0, reqReady);
      chk_flag("link reset", 1'b1, link.linkRst);
      sys_rst = 1'b0;
      repeat (20) @(negedge clk);
      issue('{1'b0, 20'h00009, 36'h000000000, 4'hF});
      drain();
      conclude();
   end
endmodule // tb_sio_burst2_sram_access
